// >>> rtl/ssf_device.sv
`timescale 1ns/1ps
module ssf_device
    import ssf_pkg::*;
(
    // system
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // cpu register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // interrupt and select pin level
    output logic            spi_irq_o,
    output logic            gp_select_o,
    // link
    ssf_link_if.device      link
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] spi_control_reg;
    logic [7:0] irq_enable_second_reg;
    logic       mode_fault_flag_reg;
    logic       fault_seen_reg;
    logic [1:0] sel_sync_reg;
    logic [1:0] sclk_sync_reg;
    logic [1:0] mosi_sync_reg;
    logic [1:0] miso_sync_reg;
    logic       sel_d_reg;
    logic       sclk_d_reg;
    logic       xfer_reg;
    logic [2:0] bit_cnt_reg;
    logic       last_bit_reg;
    logic [7:0] shift_reg;
    logic [6:0] div_cnt_reg;
    logic       m_sclk_reg;
    logic [3:0] m_edges_reg;
    logic       m_busy_reg;

    logic       spi_enable_bit;
    logic       master_select_bit;
    logic       select_pin_disable;
    logic       clock_phase_bit;
    logic [2:0] rate_field;
    logic       sel_n;
    logic       selected;
    logic       fault_master;
    logic       fault_slave;
    logic       fault_set;
    logic       ctl_wr;
    logic       sts_rd;
    logic [6:0] half_div;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       sclk_idle;
    logic       m_sample;

    assign spi_enable_bit     = spi_control_reg[CTL_ENABLE];
    assign master_select_bit  = spi_control_reg[CTL_MASTER];
    assign select_pin_disable = spi_control_reg[CTL_SEL_DISABLE];
    assign clock_phase_bit    = spi_control_reg[CTL_PHASE];
    assign rate_field = {spi_control_reg[CTL_RATE_BIT2], spi_control_reg[CTL_RATE_BIT1],
                         spi_control_reg[CTL_RATE_BIT0]};
    assign sclk_idle  = spi_control_reg[CTL_POLARITY];
    assign ctl_wr     = wr_i && (addr_i == SPI_CONTROL_ADDR);
    assign sts_rd     = rd_i && (addr_i == SPI_STATUS_ADDR);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sel_sync_reg  <= 2'h3;
            sclk_sync_reg <= 2'h0;
            mosi_sync_reg <= 2'h0;
            miso_sync_reg <= 2'h0;
        end
        else
        begin
            sel_sync_reg  <= {sel_sync_reg[0], link.sel_n_i};
            sclk_sync_reg <= {sclk_sync_reg[0], link.sclk_i};
            mosi_sync_reg <= {mosi_sync_reg[0], link.mosi_i};
            miso_sync_reg <= {miso_sync_reg[0], link.miso_i};
        end
    end

    assign sel_n     = sel_sync_reg[1];
    assign sclk_rise = sclk_sync_reg[1] && !sclk_d_reg;
    assign sclk_fall = !sclk_sync_reg[1] && sclk_d_reg;
    // slave selection, pin ignored with phase and disable set
    assign selected  = (clock_phase_bit && select_pin_disable) || !sel_n;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sel_d_reg  <= 1'b1;
            sclk_d_reg <= 1'b0;
        end
        else
        begin
            sel_d_reg  <= sel_n;
            sclk_d_reg <= sclk_sync_reg[1];
        end
    end

    // ------------------------------------------------------------
    // fault detection
    // ------------------------------------------------------------
    assign fault_master = spi_enable_bit && master_select_bit
                          && !select_pin_disable && !sel_n;
    assign fault_slave  = spi_enable_bit && !master_select_bit
                          && !(clock_phase_bit && select_pin_disable)
                          && sel_n && !sel_d_reg;
    assign fault_set    = fault_master || fault_slave;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            mode_fault_flag_reg <= 1'b0;
            fault_seen_reg      <= 1'b0;
        end
        else if (fault_set)
        begin
            mode_fault_flag_reg <= 1'b1;
            fault_seen_reg      <= 1'b0;
        end
        else if (ctl_wr && fault_seen_reg)
        begin
            mode_fault_flag_reg <= 1'b0;
            fault_seen_reg      <= 1'b0;
        end
        else if (sts_rd && mode_fault_flag_reg)
            fault_seen_reg <= 1'b1;
    end

    // ------------------------------------------------------------
    // cpu registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            spi_control_reg <= SPI_CONTROL_RESET;
        else if (fault_master)
        begin
            spi_control_reg[CTL_ENABLE] <= 1'b0;
            spi_control_reg[CTL_MASTER] <= 1'b0;
        end
        else if (ctl_wr)
        begin
            spi_control_reg <= wdata_i;
            // enable held low until the fault flag has been read in the status register
            if (mode_fault_flag_reg && !fault_seen_reg)
                spi_control_reg[CTL_ENABLE] <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            irq_enable_second_reg <= IRQ_ENABLE_RESET;
        else if (wr_i && addr_i == IRQ_ENABLE_SECOND_ADDR)
            irq_enable_second_reg <= wdata_i;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
        begin
            unique case (addr_i)
                SPI_CONTROL_ADDR:       rdata_o <= spi_control_reg;
                SPI_STATUS_ADDR:        rdata_o <= {3'h0, mode_fault_flag_reg, 4'h0};
                IRQ_ENABLE_SECOND_ADDR: rdata_o <= irq_enable_second_reg;
                default:                rdata_o <= 8'h00;
            endcase
        end
    end

    assign spi_irq_o = mode_fault_flag_reg && irq_enable_second_reg[IEN_SPI];
    assign gp_select_o = sel_n;

    // ------------------------------------------------------------
    // slave transfer tracking
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            xfer_reg     <= 1'b0;
            bit_cnt_reg  <= 3'h0;
            last_bit_reg <= 1'b0;
            shift_reg    <= 8'h00;
        end
        else if (!selected || master_select_bit || !spi_enable_bit)
        begin
            xfer_reg     <= 1'b0;
            bit_cnt_reg  <= 3'h0;
            last_bit_reg <= 1'b0;
            // master takes miso on its leading clock edge
            if (m_sample)
                shift_reg <= {shift_reg[6:0], miso_sync_reg[1]};
        end
        else
        begin
            xfer_reg <= 1'b1;
            if ((sclk_rise && !sclk_idle) || (sclk_fall && sclk_idle))
            begin
                shift_reg    <= {shift_reg[6:0], mosi_sync_reg[1]};
                last_bit_reg <= (bit_cnt_reg == BITS_PER_XFER);
                bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            end
            else if (last_bit_reg && sclk_sync_reg[1] == sclk_idle)
                last_bit_reg <= 1'b0;
        end
    end

    // slave data output floats while deselected
    assign link.miso_o     = shift_reg[7];
    assign link.miso_oe_n  = !(xfer_reg && selected && !master_select_bit);

    // ------------------------------------------------------------
    // master clock generator
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (rate_field)
            3'h1:    half_div = 7'h02;
            3'h2:    half_div = 7'h04;
            3'h3:    half_div = 7'h08;
            3'h4:    half_div = 7'h10;
            3'h5:    half_div = 7'h20;
            3'h6:    half_div = 7'h40;
            default: half_div = 7'h00;
        endcase
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            div_cnt_reg <= 7'h00;
            m_sclk_reg  <= 1'b0;
        end
        else if (!(spi_enable_bit && master_select_bit) || half_div == 7'h00)
        begin
            div_cnt_reg <= 7'h00;
            m_sclk_reg  <= sclk_idle;
        end
        else if (div_cnt_reg + 7'h01 >= half_div)
        begin
            div_cnt_reg <= 7'h00;
            m_sclk_reg  <= !m_sclk_reg;
        end
        else
            div_cnt_reg <= div_cnt_reg + 7'h01;
    end

    assign m_sample = spi_enable_bit && master_select_bit && (half_div != 7'h00)
                      && (div_cnt_reg + 7'h01 >= half_div) && (m_sclk_reg == sclk_idle);

    assign link.sclk_o     = m_sclk_reg;
    assign link.sclk_oe_n  = !(spi_enable_bit && master_select_bit);
    assign link.mosi_o     = shift_reg[7];
    assign link.mosi_oe_n  = !(spi_enable_bit && master_select_bit);
    assign link.sel_n_o    = 1'b1;
    assign link.sel_n_oe_n = 1'b1;
endmodule : ssf_device

// >>> rtl/ssf_link_if.sv
`timescale 1ns/1ps
interface ssf_link_if;
    logic sel_n_o;
    logic sel_n_oe_n;
    logic sclk_o;
    logic sclk_oe_n;
    logic mosi_o;
    logic mosi_oe_n;
    logic miso_o;
    logic miso_oe_n;
    logic ptr_sel_n_o;
    logic ptr_sel_n_oe_n;
    logic ptr_sclk_o;
    logic ptr_sclk_oe_n;
    logic ptr_mosi_o;
    logic ptr_mosi_oe_n;
    logic sel_n_i;
    logic sclk_i;
    logic mosi_i;
    logic miso_i;
    modport device (
        output sel_n_o, sel_n_oe_n, sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n,
        input  sel_n_i, sclk_i, mosi_i, miso_i
    );
    modport partner (
        output ptr_sel_n_o, ptr_sel_n_oe_n, ptr_sclk_o, ptr_sclk_oe_n, ptr_mosi_o, ptr_mosi_oe_n,
        input  miso_i
    );
endinterface : ssf_link_if

// >>> rtl/ssf_partner.sv
`timescale 1ns/1ps
module ssf_partner
    import ssf_pkg::*;
(
    // system
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    // user side
    input  wire logic select_i,
    input  wire logic drive_clock_i,
    input  wire logic mosi_bit_i,
    output logic      miso_bit_o,
    // link
    ssf_link_if.partner link
);
    logic [7:0] div_cnt_reg;
    logic       sclk_reg;
    logic [1:0] miso_sync_reg;

    // quarter-rate ceiling kept by an 8-cycle period
    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            div_cnt_reg <= 8'h00;
            sclk_reg    <= 1'b0;
        end
        else if (!drive_clock_i || !select_i)
        begin
            div_cnt_reg <= 8'h00;
            sclk_reg    <= 1'b0;
        end
        else if (div_cnt_reg + 8'h01 >= HOST_DIV_HALF)
        begin
            div_cnt_reg <= 8'h00;
            sclk_reg    <= !sclk_reg;
        end
        else
            div_cnt_reg <= div_cnt_reg + 8'h01;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            miso_sync_reg <= 2'h0;
        else
            miso_sync_reg <= {miso_sync_reg[0], link.miso_i};
    end

    assign miso_bit_o      = miso_sync_reg[1];
    assign link.ptr_sel_n_o    = !select_i;
    assign link.ptr_sel_n_oe_n = 1'b0;
    assign link.ptr_sclk_o     = sclk_reg;
    assign link.ptr_sclk_oe_n  = !select_i;
    assign link.ptr_mosi_o     = mosi_bit_i;
    assign link.ptr_mosi_oe_n  = !select_i;
endmodule : ssf_partner

// >>> rtl/ssf_pkg.sv
package ssf_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] IRQ_ENABLE_SECOND_ADDR = 8'he8;
    localparam logic [7:0] SPI_CONTROL_ADDR       = 8'hc3;
    localparam logic [7:0] SPI_STATUS_ADDR        = 8'hc4;
    localparam logic [7:0] IRQ_ENABLE_RESET       = 8'h00;
    localparam logic [7:0] SPI_CONTROL_RESET      = 8'h14;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_RATE_BIT0   = 0;
    localparam int CTL_RATE_BIT1   = 1;
    localparam int CTL_PHASE       = 2;
    localparam int CTL_POLARITY    = 3;
    localparam int CTL_MASTER      = 4;
    localparam int CTL_SEL_DISABLE = 5;
    localparam int CTL_ENABLE      = 6;
    localparam int CTL_RATE_BIT2   = 7;
    localparam int STS_MODE_FAULT  = 4;
    localparam int IEN_SPI         = 3;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          SYNC_STAGES   = 2;
    localparam logic [2:0]  BITS_PER_XFER = 3'h7;
    localparam logic [7:0]  HOST_DIV_HALF = 8'h04;
endpackage : ssf_pkg

// >>> tb/spi_select_fault_and_rate_tb.sv
`timescale 1ns/1ps
`define chk(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module spi_select_fault_and_rate_tb
    import ssf_pkg::*;
;
    logic       clock_i;
    logic       sys_rst_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       spi_irq_o;
    logic       gp_select_o;
    logic       select_i;
    logic       drive_clock_i;
    logic       tog = 1'b0;
    logic [7:0] d;
    int         bad_count;
    int         compares;

    ssf_link_if lnk ();
    // ---------------------------------------------
    // wire resolution: select pulled up, clock pulled down, data lines float
    // ---------------------------------------------
    assign lnk.sel_n_i = !lnk.ptr_sel_n_oe_n ? lnk.ptr_sel_n_o
                       : (!lnk.sel_n_oe_n ? lnk.sel_n_o : 1'b1);
    assign lnk.sclk_i  = !lnk.sclk_oe_n ? lnk.sclk_o
                       : (!lnk.ptr_sclk_oe_n ? lnk.ptr_sclk_o : 1'b0);
    assign lnk.mosi_i  = !lnk.mosi_oe_n ? lnk.mosi_o
                       : (!lnk.ptr_mosi_oe_n ? lnk.ptr_mosi_o : tog);
    assign lnk.miso_i  = lnk.miso_oe_n ? tog : lnk.miso_o;

    initial
    begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    always @(posedge clock_i) tog <= ~tog;

    ssf_device i_ssf_device (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .spi_irq_o(spi_irq_o), .gp_select_o(gp_select_o), .link(lnk));
    ssf_partner i_ssf_partner (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .select_i(select_i),
        .drive_clock_i(drive_clock_i), .mosi_bit_i(tog), .miso_bit_o(), .link(lnk));
    ssf_link_assertions i_ssf_link_assertions (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .spi_irq_o(spi_irq_o), .gp_select_o(gp_select_o), .sel_n_i(lnk.sel_n_i),
        .sclk_o(lnk.sclk_o), .sclk_oe_n(lnk.sclk_oe_n), .miso_oe_n(lnk.miso_oe_n));

    task cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cyc
    task wr(input logic [7:0] a, input logic [7:0] v);
        addr_i = a;
        wdata_i = v;
        wr_i = 1'b1;
        cyc(1);
        wr_i = 1'b0;
        cyc(1);
    endtask : wr
    task rd(input logic [7:0] a);
        addr_i = a;
        rd_i = 1'b1;
        cyc(1);
        rd_i = 1'b0;
        d = rdata_o;
        cyc(1);
    endtask : rd
    task sel(input logic v);
        select_i = v;
        cyc(6);
    endtask : sel
    task flt(input logic e);
        rd(SPI_STATUS_ADDR);
        `chk(d[STS_MODE_FAULT], e)
    endtask : flt
    // half period of master clock per rate code
    task rate(input logic [2:0] c);
        int   n;
        logic p;
        wr(SPI_CONTROL_ADDR, {c[2], 5'h14, c[1:0]});
        repeat (2)
        begin
            p = lnk.sclk_o;
            n = 0;
            while (lnk.sclk_o === p && n < 300)
            begin
                cyc(1);
                n++;
            end
        end
        `chk(n, (c == 3'h0 || c == 3'h7) ? 300 : 1 << c)
    endtask : rate
    task wrap_up;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    initial
    begin
        #400000;
        bad_count++;
        wrap_up();
    end

    initial
    begin
        {sys_rst_i, bad_count, compares} = {1'b1, 64'h0};
        {addr_i, wdata_i, wr_i, rd_i, select_i, drive_clock_i} = 20'h0;
        cyc(10);
        sys_rst_i = 1'b0;
        cyc(1);
        rd(SPI_CONTROL_ADDR);
        `chk(d, SPI_CONTROL_RESET)
        rd(IRQ_ENABLE_SECOND_ADDR);
        `chk(d, IRQ_ENABLE_RESET)
        rd(8'h00);
        `chk(d, 8'h00)
        sel(1'b1);
        sel(1'b0);
        flt(1'b0);
        // slave selected then released
        wr(IRQ_ENABLE_SECOND_ADDR, 8'h08);
        wr(SPI_CONTROL_ADDR, 8'h40);
        sel(1'b1);
        `chk(lnk.miso_oe_n, 1'b0)
        sel(1'b0);
        `chk(lnk.miso_oe_n, 1'b1)
        `chk(spi_irq_o, 1'b1)
        wr(SPI_CONTROL_ADDR, 8'h64);
        wr(SPI_CONTROL_ADDR, 8'h40);
        flt(1'b1);
        wr(IRQ_ENABLE_SECOND_ADDR, 8'h00);
        `chk(spi_irq_o, 1'b0)
        wr(IRQ_ENABLE_SECOND_ADDR, 8'h08);
        wr(SPI_CONTROL_ADDR, 8'h40);
        flt(1'b0);
        `chk(spi_irq_o, 1'b0)
        // release in mid-transfer
        sel(1'b1);
        drive_clock_i = 1'b1;
        cyc(20);
        drive_clock_i = 1'b0;
        sel(1'b0);
        flt(1'b1);
        wr(SPI_CONTROL_ADDR, 8'h64);
        sel(1'b1);
        sel(1'b0);
        flt(1'b0);
        `chk(lnk.miso_oe_n, 1'b0)
        wr(SPI_CONTROL_ADDR, 8'h71);
        sel(1'b1);
        `chk(gp_select_o, 1'b0)
        sel(1'b0);
        flt(1'b0);
        // master pulled off the bus
        wr(SPI_CONTROL_ADDR, 8'h51);
        sel(1'b1);
        rd(SPI_CONTROL_ADDR);
        `chk(d[CTL_ENABLE], 1'b0)
        `chk(d[CTL_MASTER], 1'b0)
        wr(SPI_CONTROL_ADDR, 8'h40);
        rd(SPI_CONTROL_ADDR);
        `chk(d[CTL_ENABLE], 1'b0)
        sel(1'b0);
        flt(1'b1);
        wr(SPI_CONTROL_ADDR, 8'h00);
        flt(1'b0);
        for (int c = 0; c < 8; c++)
            rate(3'(c));
        wrap_up();
    end
endmodule : spi_select_fault_and_rate_tb

// >>> tb/ssf_link_assertions.sv
`timescale 1ns/1ps
module ssf_link_assertions
    import ssf_pkg::*;
(
    // system
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // cpu side
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] rdata_o,
    input  wire logic       spi_irq_o,
    input  wire logic       gp_select_o,
    // link
    input  wire logic       sel_n_i,
    input  wire logic       sclk_o,
    input  wire logic       sclk_oe_n,
    input  wire logic       miso_oe_n
);
    logic ien_bit_reg;
    logic sel_dis_reg;

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            ien_bit_reg <= IRQ_ENABLE_RESET[IEN_SPI];
        else if (wr_i && addr_i == IRQ_ENABLE_SECOND_ADDR)
            ien_bit_reg <= wdata_i[IEN_SPI];
    end

    always_ff @(posedge clock_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            sel_dis_reg <= SPI_CONTROL_RESET[CTL_SEL_DISABLE];
        else if (wr_i && addr_i == SPI_CONTROL_ADDR)
            sel_dis_reg <= wdata_i[CTL_SEL_DISABLE];
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_desel; sel_n_i [*5]; endsequence
    sequence s_sel; !sel_n_i [*5]; endsequence
    sequence s_stat_rd;
        rd_i && addr_i == SPI_STATUS_ADDR ##1 rdata_o[STS_MODE_FAULT] && ien_bit_reg;
    endsequence

    property p_float; s_desel |-> miso_oe_n || sel_dis_reg; endproperty
    property p_sclk; $changed(sclk_o) && !sclk_oe_n |=> $stable(sclk_o); endproperty
    property p_gate; spi_irq_o |-> ien_bit_reg; endproperty
    property p_raise; s_stat_rd |-> spi_irq_o; endproperty
    property p_hold; $fell(spi_irq_o) |-> $past(wr_i); endproperty
    property p_gp_hi; s_desel |-> gp_select_o; endproperty
    property p_gp_lo; s_sel |-> !gp_select_o; endproperty
    property p_rdata; $changed(rdata_o) |-> $past(rd_i); endproperty

    a_float: assert property (p_float) else $error("miso driven");
    a_sclk: assert property (p_sclk) else $error("sclk too fast");
    a_gate: assert property (p_gate) else $error("irq not gated");
    a_raise: assert property (p_raise) else $error("irq missing");
    a_hold: assert property (p_hold) else $error("irq dropped");
    a_gp_hi: assert property (p_gp_hi) else $error("gp level");
    a_gp_lo: assert property (p_gp_lo) else $error("gp level");
    a_rdata: assert property (p_rdata) else $error("rdata moved");
endmodule : ssf_link_assertions
